// ---- pkg/tmrec_pkg.sv ----
package tmrec_pkg;
  localparam int unsigned TMREC_AW = 2;
  localparam int unsigned TMREC_DW = 8;
  // register offsets
  localparam logic [1:0] TMREC_OFF_COUNT = 2'h0;
  localparam logic [1:0] TMREC_OFF_CTRL = 2'h1;
  localparam logic [1:0] TMREC_OFF_AUX = 2'h2;
  // control fields
  localparam int unsigned TMREC_MODE_HI = 7;
  localparam int unsigned TMREC_MODE_LO = 6;
  localparam int unsigned TMREC_RUN_BIT = 4;
  localparam int unsigned TMREC_EDGE_BIT = 3;
  localparam int unsigned TMREC_PSC_HI = 2;
  localparam int unsigned TMREC_PSC_LO = 0;
  localparam logic [7:0] TMREC_CTRL_RST = 8'h08;
  localparam logic [7:0] TMREC_CTRL_WMASK = 8'hDF;
  // aux fields: clock source select and interrupt enable
  localparam int unsigned TMREC_CLKSEL_HI = 1;
  localparam int unsigned TMREC_CLKSEL_LO = 0;
  localparam int unsigned TMREC_INTEN_BIT = 2;
  localparam logic [7:0] TMREC_AUX_RST = 8'h00;
  localparam logic [7:0] TMREC_AUX_WMASK = 8'h07;
  // counter constants
  localparam logic [7:0] TMREC_FULL = 8'hFF;
  localparam logic [7:0] TMREC_ONE = 8'h01;
  localparam logic [7:0] TMREC_ZERO = 8'h00;
  localparam logic [1:0] TMREC_INSTR_LAST = 2'h3;
  localparam logic [1:0] TMREC_DIV_ONE = 2'h1;
  localparam int unsigned TMREC_PSC_MIN_W = 7;

  typedef enum logic [1:0]
  {
    TMREC_MODE_NONE = 2'h0,
    TMREC_MODE_EVENT = 2'h1,
    TMREC_MODE_TIMER = 2'h2,
    TMREC_MODE_PWC = 2'h3
  } tmrec_mode_t;

  typedef enum logic [1:0]
  {
    TMREC_SRC_SYS = 2'h0,
    TMREC_SRC_INSTR = 2'h1,
    TMREC_SRC_LOW = 2'h2,
    TMREC_SRC_LOW_ALT = 2'h3
  } tmrec_src_t;

  // pulse capture states, gray along idle -> armed -> measuring
  typedef enum logic [1:0]
  {
    TMREC_PWC_IDLE = 2'b00,
    TMREC_PWC_ARM = 2'b01,
    TMREC_PWC_MEAS = 2'b11
  } tmrec_pwc_t;

  typedef struct packed
  {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmrec_bus_t;
endpackage

// ---- hdl/tmrec_top.sv ----
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module tmrec_top
  import tmrec_pkg::*;
#(
  parameter int unsigned PSC_W = 7
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire tmrec_bus_t bus_i,
  output logic [7:0] rdata_o,
  // external count pin and clock sources
  input wire logic ext_count_pin_i,
  input wire logic low_speed_osc_i,
  input wire logic sleep_i,
  // events
  output logic ovf_o,
  output logic irq_o,
  output logic wake_o
);

  // prescaler must hold the divide-by-128 tap
  if (PSC_W < TMREC_PSC_MIN_W)
  begin : g_bad_psc
    $error("prescaler width too small");
  end

  // true on the cycle the prescaled clock falls
  function automatic logic presc_fall(input logic [PSC_W-1:0] cnt,
                                      input logic [2:0] sel);
    logic [PSC_W-1:0] mask;
    mask = PSC_W'((1 << sel) - 1);
    return &(cnt | ~mask);
  endfunction

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] aux_q, aux_d;
  logic [7:0] preload_q, preload_d;
  logic [7:0] count_q, count_d;
  logic [7:0] rdata_q, rdata_d;
  logic sync1_q, sync2_q, prev_q;
  logic [PSC_W-1:0] presc_q, presc_d;
  logic [1:0] div4_q, div4_d;
  tmrec_pwc_t pwc_q, pwc_d;
  logic ovf_q, ovf_d, irq_q, irq_d, wake_q, wake_d;

  tmrec_mode_t mode;
  tmrec_src_t src;
  logic run, edge_sel, int_en;
  logic [2:0] psc;
  logic wr_count, rd_count, wr_ctrl, wr_aux, inhibit;
  logic rise, fall, active_edge, start_edge, stop_edge;
  logic src_tick, presc_tick, count_tick, ovf_evt, pwc_act;

  // field decode
  assign mode = tmrec_mode_t'(ctrl_q[TMREC_MODE_HI:TMREC_MODE_LO]);
  assign run = ctrl_q[TMREC_RUN_BIT];
  assign edge_sel = ctrl_q[TMREC_EDGE_BIT];
  assign psc = ctrl_q[TMREC_PSC_HI:TMREC_PSC_LO];
  assign src = tmrec_src_t'(aux_q[TMREC_CLKSEL_HI:TMREC_CLKSEL_LO]);
  assign int_en = aux_q[TMREC_INTEN_BIT];

  // bus decode
  always_comb
  begin
    wr_count = 1'b0;
    rd_count = 1'b0;
    wr_ctrl = 1'b0;
    wr_aux = 1'b0;
    if (bus_i.addr == TMREC_OFF_COUNT)
    begin
      wr_count = bus_i.wr;
      rd_count = bus_i.rd;
    end
    else if (bus_i.addr == TMREC_OFF_CTRL)
    begin
      wr_ctrl = bus_i.wr;
    end
    else if (bus_i.addr == TMREC_OFF_AUX)
    begin
      wr_aux = bus_i.wr;
    end
  end

  // freeze the count during a count register access so the value is not torn
  assign inhibit = wr_count | rd_count;

  // pin edges, only the second stage is looked at
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign active_edge = edge_sel ? fall : rise;
  assign start_edge = edge_sel ? rise : fall;
  assign stop_edge = edge_sel ? fall : rise;

  // internal source; system clocks stop in sleep, the slow osc runs on
  always_comb
  begin
    case (src)
      TMREC_SRC_SYS: src_tick = ~sleep_i;
      TMREC_SRC_INSTR: src_tick = ~sleep_i & (div4_q == TMREC_INSTR_LAST);
      default: src_tick = low_speed_osc_i;
    endcase
    div4_d = sleep_i ? div4_q : div4_q + TMREC_DIV_ONE;
    presc_d = src_tick ? presc_q + PSC_W'(1) : presc_q;
  end

  assign presc_tick = src_tick & presc_fall(presc_q, psc);
  assign pwc_act = run & (mode == TMREC_MODE_PWC);

  // count qualification per mode
  always_comb
  begin
    case (mode)
      TMREC_MODE_EVENT: count_tick = active_edge;
      TMREC_MODE_TIMER: count_tick = presc_tick;
      TMREC_MODE_PWC: count_tick = presc_tick & (pwc_q == TMREC_PWC_MEAS);
      default: count_tick = 1'b0;
    endcase
    count_tick = count_tick & run & ~inhibit;
  end

  assign ovf_evt = count_tick & (count_q == TMREC_FULL);

  // pulse capture sequencer
  always_comb
  begin
    pwc_d = pwc_q;
    case (pwc_q)
      TMREC_PWC_IDLE:
        if (pwc_act)
          pwc_d = TMREC_PWC_ARM;
      TMREC_PWC_ARM:
        if (!pwc_act)
          pwc_d = TMREC_PWC_IDLE;
        else if (start_edge)
          pwc_d = TMREC_PWC_MEAS;
      TMREC_PWC_MEAS:
        if (!pwc_act || stop_edge)
          pwc_d = TMREC_PWC_IDLE;
      default: pwc_d = TMREC_PWC_IDLE;
    endcase
  end

  // registers; a software write wins over the capture auto clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    aux_d = aux_q;
    preload_d = preload_q;
    count_d = count_q;
    if (wr_ctrl)
      ctrl_d = bus_i.wdata & TMREC_CTRL_WMASK;
    else if (pwc_act && pwc_q == TMREC_PWC_MEAS && stop_edge)
      ctrl_d[TMREC_RUN_BIT] = 1'b0;
    if (wr_aux)
      aux_d = bus_i.wdata & TMREC_AUX_WMASK;
    if (wr_count)
      preload_d = bus_i.wdata;
    if (wr_count && !run)
      count_d = bus_i.wdata;
    else if (ovf_evt)
      count_d = preload_q;
    else if (count_tick)
      count_d = count_q + TMREC_ONE;
  end

  // events and read data
  always_comb
  begin
    ovf_d = ovf_evt;
    irq_d = ovf_evt & int_en;
    wake_d = ovf_evt;
    rdata_d = TMREC_ZERO;
    if (bus_i.rd)
    begin
      if (bus_i.addr == TMREC_OFF_COUNT)
        rdata_d = count_q;
      else if (bus_i.addr == TMREC_OFF_CTRL)
        rdata_d = ctrl_q;
      else if (bus_i.addr == TMREC_OFF_AUX)
        rdata_d = aux_q;
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q <= TMREC_CTRL_RST;
      aux_q <= TMREC_AUX_RST;
      preload_q <= TMREC_ZERO;
      count_q <= TMREC_ZERO;
      rdata_q <= TMREC_ZERO;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      presc_q <= '0;
      div4_q <= 2'h0;
      pwc_q <= TMREC_PWC_IDLE;
      ovf_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      aux_q <= aux_d;
      preload_q <= preload_d;
      count_q <= count_d;
      rdata_q <= rdata_d;
      sync1_q <= ext_count_pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      presc_q <= presc_d;
      div4_q <= div4_d;
      pwc_q <= pwc_d;
      ovf_q <= ovf_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
    end
  end

  assign rdata_o = rdata_q;
  assign ovf_o = ovf_q;
  assign irq_o = irq_q;
  assign wake_o = wake_q;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  chk_bit5_zero: assert property (ctrl_q[5] == 1'b0)
    else $error("control bit 5 not zero");

  chk_mode_decode: assert property (
    (mode != TMREC_MODE_EVENT && mode != TMREC_MODE_TIMER &&
     mode != TMREC_MODE_PWC) |-> !count_tick)
    else $error("count in no-mode");

  chk_halt_when_off: assert property (
    (!run && !wr_count) |=> count_q == $past(count_q))
    else $error("counter moved while stopped");

  chk_preload_direct: assert property (
    (wr_count && !run) |=> count_q == $past(bus_i.wdata))
    else $error("stopped preload not copied");

  chk_preload_held: assert property (
    (wr_count && run) |=> count_q == $past(count_q) &&
    preload_q == $past(bus_i.wdata))
    else $error("running preload leaked into counter");

  chk_read_freeze: assert property (
    rd_count |=> count_q == $past(count_q))
    else $error("counter moved during read");

  chk_ovf_reload: assert property (
    (count_tick && count_q == TMREC_FULL && !wr_count) |=>
    ovf_o && count_q == $past(preload_q))
    else $error("overflow reload wrong");

  chk_irq_gate: assert property (
    irq_o |-> ovf_o && $past(int_en))
    else $error("interrupt not gated");

  chk_event_edge: assert property (
    (mode == TMREC_MODE_EVENT && run && !edge_sel && rise &&
     !inhibit && count_q != TMREC_FULL) |=>
    count_q == $past(count_q) + TMREC_ONE)
    else $error("event rise not counted");

  chk_pwc_autoclr: assert property (
    (pwc_act && pwc_q == TMREC_PWC_MEAS && stop_edge && !wr_ctrl) |=>
    !run ##1 pwc_q == TMREC_PWC_IDLE)
    else $error("capture run bit not cleared");

  chk_wake_any: assert property (
    ovf_o |-> wake_o)
    else $error("overflow without wake");

  chk_pwc_armed_hold: assert property (
    (pwc_q == TMREC_PWC_ARM) |-> !count_tick)
    else $error("capture counted before start edge");

  chk_timer_step: assert property (
    (mode == TMREC_MODE_TIMER && count_tick && count_q != TMREC_FULL) |=>
    count_q == $past(count_q) + TMREC_ONE)
    else $error("timer tick not counted");

  cov_overflow: cover property (ovf_o && irq_o);
  cov_event_tick: cover property (mode == TMREC_MODE_EVENT && count_tick);
  cov_pwc_done: cover property (pwc_q == TMREC_PWC_MEAS ##1
                                pwc_q == TMREC_PWC_IDLE);
  cov_sleep_event: cover property (sleep_i && wake_o);
endmodule

// ---- verif/tmrec_pin_src.sv ----
`timescale 1ns/1ps
module tmrec_pin_src
#(
  parameter int unsigned GAP = 6
)
(
  // clock
  input wire logic clk_i,
  // request
  input wire logic go_i,
  input wire logic idle_lvl_i,
  input wire logic [7:0] pulses_i,
  input wire logic [7:0] width_i,
  // pin side
  output logic pin_o,
  output logic busy_o
);
  // pulse source; levels held long enough for a two-flop sync
  initial
  begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i === 1'b1)
      begin
        busy_o <= 1'b1;
        repeat (pulses_i)
        begin
          pin_o <= ~idle_lvl_i;
          repeat (width_i) @(posedge clk_i);
          pin_o <= idle_lvl_i;
          repeat (GAP) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
      else
        pin_o <= idle_lvl_i;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tmrec_pkg::*;
  logic clk_i, nrst_i, pin, go, idle, busy, sleep_i;
  logic osc = 1'b0;
  logic ovf_o, irq_o, wake_o;
  logic [7:0] rdata_o, np, wd, d;
  tmrec_bus_t bus;
  int n_fail, samples_checked, t, t1, i, e;
  int cyc = 0;
  int lsc = 0;

  tmrec_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus),
    .rdata_o(rdata_o), .ext_count_pin_i(pin), .low_speed_osc_i(osc),
    .sleep_i(sleep_i), .ovf_o(ovf_o), .irq_o(irq_o), .wake_o(wake_o));
  tmrec_pin_src src (.clk_i(clk_i), .go_i(go), .idle_lvl_i(idle),
    .pulses_i(np), .width_i(wd), .pin_o(pin), .busy_o(busy));

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // cycle stamp; low-speed tick every 10 cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    lsc <= (lsc == 9) ? 0 : lsc + 1;
    osc <= (lsc == 9);
  end

  task automatic final_report();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk_rng(input logic [15:0] g, lo, hi);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t got %0d exp %0d..%0d", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [1:0] a, input logic [7:0] x);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata_o;
    chk8(d, x);
  endtask

  // plain read into d, for results checked by range
  task automatic rdv(input logic [1:0] a);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic hang(input logic ok);
    if (!ok)
    begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask

  task automatic wait_ovf(input logic ie);
    int k;
    for (k = 0; k < 5000; k++)
    begin
      @(posedge clk_i);
      #1;
      if (ovf_o === 1'b1)
        break;
    end
    hang(k < 5000);
    t = cyc;
    chk8({7'h00, irq_o}, {7'h00, ie});
    chk8({7'h00, wake_o}, 8'h01);
  endtask

  task automatic pulse(input logic lv, input logic [7:0] n, w);
    int k;
    idle <= lv;
    np <= n;
    wd <= w;
    repeat (8) @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask

  task automatic wait_src();
    int k;
    for (k = 0; k < 3000; k++)
    begin
      @(posedge clk_i);
      #1;
      if (busy === 1'b0)
        break;
    end
    hang(k < 3000);
    // last pin edge needs sync and detect cycles to reach the counter
    repeat (4) @(posedge clk_i);
  endtask

  // main sequence
  initial
  begin
    nrst_i = 1'b0;
    bus = '0;
    go = 1'b0;
    idle = 1'b0;
    np = 8'h00;
    wd = 8'h00;
    sleep_i = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc(TMREC_OFF_CTRL, 8'h08);
    rdc(TMREC_OFF_AUX, 8'h00);
    rdc(TMREC_OFF_COUNT, 8'h00);
    wr(2'h3, 8'hFF);
    rdc(2'h3, 8'h00);
    wr(TMREC_OFF_CTRL, 8'hFF);
    rdc(TMREC_OFF_CTRL, 8'hDF);
    $display("test registers done");
    // timer periods: preload F0 gives 16 ticks per overflow
    wr(TMREC_OFF_CTRL, 8'h80);
    wr(TMREC_OFF_COUNT, 8'hF0);
    for (i = 0; i < 10; i++)
    begin
      e = (i < 8) ? (16 << i) : (i == 8) ? 64 : 160;
      wr(TMREC_OFF_AUX, {5'h00, i[0], (i > 7) ? 2'(i - 7) : 2'h0});
      wr(TMREC_OFF_CTRL, {5'h12, (i > 7) ? 3'h0 : 3'(i)});
      wait_ovf(i[0]);
      t1 = t;
      wait_ovf(i[0]);
      chk_rng(16'(t - t1), 16'(e), 16'(e));
    end
    wr(TMREC_OFF_AUX, 8'h00);
    wr(TMREC_OFF_CTRL, 8'h90);
    wait_ovf(1'b0);
    t1 = t;
    wr(TMREC_OFF_COUNT, 8'hF8);
    wait_ovf(1'b0);
    chk_rng(16'(t - t1), 16'h0011, 16'h0011);
    t1 = t;
    wait_ovf(1'b0);
    chk_rng(16'(t - t1), 16'h0008, 16'h0008);
    wr(TMREC_OFF_CTRL, 8'h80);
    wr(TMREC_OFF_COUNT, 8'h33);
    repeat (20) @(posedge clk_i);
    rdc(TMREC_OFF_COUNT, 8'h33);
    wr(TMREC_OFF_CTRL, 8'h10);
    repeat (20) @(posedge clk_i);
    rdc(TMREC_OFF_COUNT, 8'h33);
    $display("test timer done");
    // event mode, both edges, prescaler at 128 must not matter
    for (i = 0; i < 2; i++)
    begin
      wr(TMREC_OFF_CTRL, {4'h4, i[0], 3'h7});
      wr(TMREC_OFF_COUNT, 8'h00);
      wr(TMREC_OFF_CTRL, {4'h5, i[0], 3'h7});
      pulse(1'b0, 8'h03, 8'h14);
      repeat (10) @(posedge clk_i);
      rdc(TMREC_OFF_COUNT, i[0] ? 8'h00 : 8'h01);
      wait_src();
      rdc(TMREC_OFF_COUNT, 8'h03);
    end
    wr(TMREC_OFF_CTRL, 8'h40);
    wr(TMREC_OFF_COUNT, 8'hFE);
    wr(TMREC_OFF_AUX, 8'h04);
    wr(TMREC_OFF_CTRL, 8'h50);
    sleep_i <= 1'b1;
    pulse(1'b0, 8'h02, 8'h08);
    wait_ovf(1'b1);
    wait_src();
    sleep_i <= 1'b0;
    rdc(TMREC_OFF_COUNT, 8'hFE);
    $display("test event done");
    // single-shot pulse width capture
    wr(TMREC_OFF_AUX, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(TMREC_OFF_CTRL, {4'hC, i[0], 3'h0});
      idle <= ~i[0];
      wr(TMREC_OFF_COUNT, 8'h00);
      wr(TMREC_OFF_CTRL, {4'hD, i[0], 3'h0});
      pulse(~i[0], 8'h01, 8'h1E);
      wait_src();
      rdv(TMREC_OFF_COUNT);
      chk_rng({8'h00, d}, 16'h001C, 16'h0020);
      rdc(TMREC_OFF_CTRL, {4'hC, i[0], 3'h0});
      pulse(~i[0], 8'h01, 8'h1E);
      wait_src();
      rdv(TMREC_OFF_COUNT);
      chk_rng({8'h00, d}, 16'h001C, 16'h0020);
    end
    $display("test capture done");
    final_report();
  end
endmodule
